// *** sim/multiplier_contention_interlock_chk.sv ***
`timescale 1ns/1ps
module multiplier_contention_interlock_chk
  import interlock_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic decode_valid,
  input wire op_class_t decode_op,
  input wire logic accumulate_last_access,
  input wire logic fetch_request,
  input wire logic decode_stall,
  input wire logic mult_access,
  input wire logic fetch_grant,
  input wire logic access_busy,
  input wire logic gpr_write
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  a_reset_outputs_idle: assert property ($past(reset) |->
    !(decode_stall | mult_access | access_busy | fetch_grant | gpr_write))
    else $error("reset idle");
  a_tail_blocks_access: assert property (accumulate_last_access
    |=> !mult_access ##1 !mult_access) else $error("access in busy tail");
  a_stretch_ends_access: assert property ($rose(access_busy) |-> ##[1:8] mult_access)
    else $error("stretch never ended");
  a_access_single_slot: assert property (mult_access |=> !mult_access)
    else $error("access longer than one cycle");
  a_access_clears_busy: assert property (mult_access |-> !access_busy)
    else $error("busy with access");
  a_split_slot: assert property (mult_access |-> !fetch_grant)
    else $error("fetch and access share cycle");
  a_busy_stalls_decode: assert property ($rose(access_busy) |-> decode_stall)
    else $error("busy without stall");
  a_write_after_access: assert property (gpr_write |-> $past(mult_access))
    else $error("write without access");
  a_accumulate_decode_stall: assert property (decode_op == op_multiply_accumulate_word
    && decode_valid && !decode_stall && !access_busy |-> ##[1:2] decode_stall)
    else $error("no stall");
endmodule

bind multiplier_contention_interlock multiplier_contention_interlock_chk u_chk (.clk(clk),
  .reset(reset), .decode_valid(decode_valid), .decode_op(decode_op),
  .accumulate_last_access(accumulate_last_access), .fetch_request(fetch_request),
  .decode_stall(decode_stall), .mult_access(mult_access), .fetch_grant(fetch_grant),
  .access_busy(access_busy), .gpr_write(gpr_write));

// *** sim/multiplier_contention_interlock_test.sv ***
`timescale 1ns/1ps
module multiplier_contention_interlock_test;
  import interlock_pkg::*;
  logic clk, reset, decode_valid, accumulate_last_access, fetch_request;
  logic decode_stall, mult_access, fetch_grant, access_busy, gpr_write;
  op_class_t decode_op;
  int n_fail, total_checks;
  multiplier_contention_interlock u_dut (.clk(clk), .reset(reset), .decode_valid(decode_valid),
    .decode_op(decode_op), .accumulate_last_access(accumulate_last_access),
    .fetch_request(fetch_request), .decode_stall(decode_stall), .mult_access(mult_access),
    .fetch_grant(fetch_grant), .access_busy(access_busy), .gpr_write(gpr_write));
  initial
  begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d fails %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task issue(input op_class_t op, input logic acc, input logic f);
    @(posedge clk);
    decode_valid <= 1'h1;
    decode_op <= op;
    accumulate_last_access <= acc;
    fetch_request <= f;
    @(posedge clk);
    decode_valid <= 1'h0;
    decode_op <= op_none;
    accumulate_last_access <= 1'h0;
  endtask
  // ----------------------------------------------------------------
  // Scenarios; waits are bounded so a hung stage shows as a mismatch
  // ----------------------------------------------------------------
  task t_contend(input op_class_t op, input logic f);
    int n;
    logic b, g;
    n = 0;
    b = 1'h0;
    g = 1'h0;
    issue(op, 1'h1, f);
    do
    begin
      @(negedge clk);
      n++;
      b |= (access_busy === 1'h1);
      g |= (fetch_grant === 1'h1);
    end
    while (mult_access !== 1'h1 && n < 12);
    chk(n >= 3 && n < 12, 1'h1);
    chk(b, 1'h1);
    chk(g, f);
    @(negedge clk);
    chk(gpr_write, op == op_store_system_register);
    @(posedge clk);
    fetch_request <= 1'h0;
    repeat (4) @(posedge clk);
    $display("contend test done");
  endtask
  task t_gap;
    int n;
    logic [7:0] ns;
    n = 0;
    ns = 8'h00;
    issue(op_other, 1'h1, 1'h0);
    issue(op_other, 1'h0, 1'h0);
    issue(op_signed_multiply_word, 1'h0, 1'h0);
    do
    begin
      @(negedge clk);
      n++;
      if (decode_stall === 1'h1)
        ns = ns + 8'h01;
    end
    while (mult_access !== 1'h1 && n < 12);
    chk(n < 4, 1'h1);
    chk(ns, 8'h01);
    repeat (4) @(posedge clk);
    $display("gap test done");
  endtask
  task t_accumulate_stall;
    logic s;
    issue(op_multiply_accumulate_word, 1'h0, 1'h0);
    @(negedge clk);
    s = (decode_stall === 1'h1);
    @(negedge clk);
    s |= (decode_stall === 1'h1);
    chk(s, 1'h1);
    repeat (4) @(posedge clk);
    $display("accumulate stall test done");
  endtask
  initial
  begin
    reset = 1'h1;
    decode_valid = 1'h0;
    decode_op = op_none;
    accumulate_last_access = 1'h0;
    fetch_request = 1'h0;
    repeat (2) @(posedge clk);
    reset <= 1'h0;
    for (int f = 0; f < 2; f++)
    begin
      t_contend(op_signed_multiply_word, f[0]);
      t_contend(op_store_system_register, f[0]);
    end
    t_gap;
    t_accumulate_stall;
    complete_run;
  end
  initial
  begin
    #100000;
    n_fail++;
    complete_run;
  end
endmodule

// *** verilog/interlock_pkg.sv ***
package interlock_pkg;

  // ----------------------------------------------------------------
  // Instruction classes seen at decode
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    op_other,
    op_multiply_accumulate_word,
    op_signed_multiply_word,
    op_store_system_register,
    op_none
  } op_class_t;

  // ----------------------------------------------------------------
  // Timing counts in cycles; gap counts in unrelated instructions
  // ----------------------------------------------------------------
  localparam logic [1:0] busy_tail_cycles = 2'h2;
  localparam logic [1:0] decode_stall_slots = 2'h1;
  localparam logic [1:0] gap_for_no_stall = 2'h2;
  localparam logic [1:0] gap_max = 2'h3;
  localparam logic [1:0] busy_zero = 2'h0;
  localparam logic [1:0] count_one = 2'h1;

endpackage

// *** verilog/mult_busy_tracker.sv ***
`timescale 1ns/1ps

module mult_busy_tracker
  import interlock_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  mult_link_if.track link
);

  logic [1:0] busy_cnt_q;
  logic [1:0] busy_cnt_d;
  logic [1:0] gap_q;
  logic [1:0] gap_d;

  // ----------------------------------------------------------------
  // Busy tail and count of unrelated instructions since the last accumulate word
  // ----------------------------------------------------------------
  always_comb
  begin
    busy_cnt_d = busy_cnt_q;
    gap_d = gap_q;
    if (link.accumulate_last_access)
    begin
      // Tail runs on cycles, not slots
      busy_cnt_d = busy_tail_cycles;
      gap_d = busy_zero;
    end
    else
    begin
      if (busy_cnt_q != busy_zero)
      begin
        busy_cnt_d = busy_cnt_q - count_one;
      end
      if (link.other_retire && gap_q != gap_max)
      begin
        gap_d = gap_q + count_one;
      end
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      busy_cnt_q <= busy_zero;
      gap_q <= gap_max;
    end
    else
    begin
      busy_cnt_q <= busy_cnt_d;
      gap_q <= gap_d;
    end
  end

  assign link.busy = (busy_cnt_q != busy_zero);
  assign link.gap = gap_q;

endmodule

// *** verilog/mult_link_if.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Link between interlock control and the multiplier busy tracker
// ----------------------------------------------------------------
interface mult_link_if;
  logic accumulate_last_access;
  logic busy;
  logic [1:0] gap;
  logic other_retire;

  modport ctrl (output accumulate_last_access, output other_retire, input busy, input gap);
  modport track (input accumulate_last_access, input other_retire, output busy, output gap);
endinterface

// *** verilog/multiplier_contention_interlock.sv ***
`timescale 1ns/1ps

// Operation
// - A signed multiply word gets a memory access stage that reaches the multiplier.
// - That stage stretches as one slot while an accumulate word keeps the multiplier busy.
// - Two or more unrelated instructions after an accumulate word mean no contention stall.
// - A signed multiply memory stage meeting a fetch splits the slot with it.
// - A store of the accumulator to a general register gets a multiplier access stage.
// - That stage stretches while the multiplier is busy, forming one slot.
// - That stage contends with instruction fetch and goes through fetch arbitration.
// - The multiplier stays busy two cycles after the last accumulate word memory stage.
// - Decode of the instruction after an accumulate word stalls one slot.
module multiplier_contention_interlock
  import interlock_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic decode_valid,
  input wire op_class_t decode_op,
  input wire logic accumulate_last_access,
  input wire logic fetch_request,
  output logic decode_stall,
  output logic mult_access,
  output logic fetch_grant,
  output logic access_busy,
  output logic gpr_write
);

  // ----------------------------------------------------------------
  // Stage states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    st_idle,
    st_access_wait,
    st_access_split,
    st_write_back
  } state_t;

  mult_link_if link ();

  // ----------------------------------------------------------------
  // Sequencing state
  // ----------------------------------------------------------------
  state_t state_q;
  state_t state_d;
  op_class_t held_op_q;
  op_class_t held_op_d;
  logic [1:0] stall_cnt_q;
  logic [1:0] stall_cnt_d;
  logic contends;

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic decode_stall_q;
  logic decode_stall_d;
  logic mult_access_q;
  logic mult_access_d;
  logic fetch_grant_q;
  logic fetch_grant_d;
  logic access_busy_q;
  logic access_busy_d;
  logic gpr_write_q;
  logic gpr_write_d;

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  // Followers that must meet the multiplier
  function automatic logic uses_multiplier(input op_class_t op);
    uses_multiplier = (op == op_signed_multiply_word) || (op == op_store_system_register);
  endfunction

  // Only the accumulator store has a writeback of its own
  function automatic logic writes_register(input op_class_t op);
    writes_register = (op == op_store_system_register);
  endfunction

  function automatic state_t after_access(input op_class_t op);
    if (writes_register(op))
    begin
      after_access = st_write_back;
    end
    else
    begin
      after_access = st_idle;
    end
  endfunction

  // ----------------------------------------------------------------
  // Multiplier busy tracker
  // ----------------------------------------------------------------
  mult_busy_tracker tracker (
    .clk(clk),
    .reset(reset),
    .link(link)
  );

  assign link.accumulate_last_access = accumulate_last_access;
  // Only unstalled decodes count toward the gap
  assign link.other_retire = decode_valid && !decode_stall_q && !access_busy_q
    && (decode_op == op_other);

  // Contention only while busy and fewer than two unrelated ops since the accumulate
  assign contends = link.busy && (link.gap < gap_for_no_stall);

  // ----------------------------------------------------------------
  // Memory access sequencing for multiplier users
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    held_op_d = held_op_q;
    stall_cnt_d = stall_cnt_q;
    decode_stall_d = 1'b0;
    mult_access_d = 1'b0;
    // Fetch keeps the bus whenever no stage claims it
    fetch_grant_d = fetch_request;
    access_busy_d = 1'b0;
    gpr_write_d = 1'b0;
    if (stall_cnt_q != busy_zero)
    begin
      stall_cnt_d = stall_cnt_q - count_one;
    end
    unique case (state_q)
      st_idle:
      begin
        if (decode_valid && decode_op == op_multiply_accumulate_word)
        begin
          stall_cnt_d = decode_stall_slots;
        end
        if (stall_cnt_q != busy_zero)
        begin
          decode_stall_d = 1'b1;
        end
        else if (decode_valid && uses_multiplier(decode_op))
        begin
          held_op_d = decode_op;
          state_d = st_access_wait;
          access_busy_d = 1'b1;
          decode_stall_d = 1'b1;
        end
      end
      st_access_wait:
      begin
        access_busy_d = 1'b1;
        decode_stall_d = 1'b1;
        if (contends)
        begin
          // Stretched stage is still one slot
          state_d = st_access_wait;
        end
        else if (fetch_request)
        begin
          // Fetch takes first half of the split slot
          fetch_grant_d = 1'b1;
          state_d = st_access_split;
        end
        else
        begin
          fetch_grant_d = 1'b0;
          mult_access_d = 1'b1;
          // Decode stays held over writeback so no instruction is dropped there
          decode_stall_d = writes_register(held_op_q);
          access_busy_d = 1'b0;
          state_d = after_access(held_op_q);
        end
      end
      st_access_split:
      begin
        fetch_grant_d = 1'b0;
        mult_access_d = 1'b1;
        decode_stall_d = writes_register(held_op_q);
        state_d = after_access(held_op_q);
      end
      st_write_back:
      begin
        gpr_write_d = 1'b1;
        held_op_d = op_none;
        state_d = st_idle;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State and output registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      state_q <= st_idle;
      held_op_q <= op_none;
      stall_cnt_q <= busy_zero;
      decode_stall_q <= 1'b0;
      mult_access_q <= 1'b0;
      fetch_grant_q <= 1'b0;
      access_busy_q <= 1'b0;
      gpr_write_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      held_op_q <= held_op_d;
      stall_cnt_q <= stall_cnt_d;
      decode_stall_q <= decode_stall_d;
      mult_access_q <= mult_access_d;
      fetch_grant_q <= fetch_grant_d;
      access_busy_q <= access_busy_d;
      gpr_write_q <= gpr_write_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign decode_stall = decode_stall_q;
  assign mult_access = mult_access_q;
  assign fetch_grant = fetch_grant_q;
  assign access_busy = access_busy_q;
  assign gpr_write = gpr_write_q;

endmodule
